// ### llc_map.vh
// Register map, field positions, reset values and timing figures for the
// line loopback controller. Included by the top design file and the bench.
`ifndef LLC_MAP_VH
`define LLC_MAP_VH

// Byte addresses of the APB registers
`define LLC_LOOP_CTRL_ADDR     12'h000
`define LLC_DETECT_CFG_ADDR    12'h004
`define LLC_STATUS_ADDR        12'h008

// Loop control register fields
`define LLC_ANALOG_BIT         0
`define LLC_REMOTE_BIT         1
`define LLC_DIGITAL_BIT        2
`define LLC_AUTO_BIT           3

// Pattern detect configuration field
`define LLC_SIDE_SEL_BIT       3

// Primary status word fields
`define LLC_ST_REMOTE_BIT      0
`define LLC_ST_DIGITAL_BIT     1
`define LLC_ST_ANALOG_BIT      2
`define LLC_ST_AUTO_BIT        7

// Reset values
`define LLC_LOOP_CTRL_RST      4'h0
`define LLC_DETECT_CFG_RST     1'b0

// Persistence time of an inband code, and the clock rate
`define LLC_PERSIST_MS         5100
`define LLC_CLK_KHZ            100000

`endif

// ### llc_persist.v
// Persistence qualifier for the activate and deactivate inband code levels.
// Assumes the code levels are synchronous to ref_clk and held while seen.
`timescale 1ns/10ps
`default_nettype none

module llc_persist
#(
	parameter [31:0] PERSIST_CYCLES = 32'h1E65_FB80
)
(
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire [1:0]  code_level,
	output wire [1:0]  code_held
);

	genvar g;

	// One counter per code: index 0 activate, index 1 deactivate
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_code
			reg  [31:0] count;   // Cycles the level has stood
			reg         fired;   // Pulse when it stood long enough
			// Counts while the level stands; pulses once past the limit
			always @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					count <= 32'h0000_0000;
					fired <= 1'b0;
				end
				else if (!code_level[g])
				begin
					// Level dropped: restart the wait
					count <= 32'h0000_0000;
					fired <= 1'b0;
				end
				else if (count <= PERSIST_CYCLES)
				begin
					// Strictly more than the time: fire one count past it
					count <= count + 32'h0000_0001;
					fired <= (count == PERSIST_CYCLES);
				end
				else
				begin
					// Saturated: hold and stay quiet
					fired <= 1'b0;
				end
			end
			assign code_held[g] = fired;
		end
	endgenerate

endmodule

`default_nettype wire

// ### llc_top.v
// Line loopback controller for one line interface channel: APB registers,
// automatic inband loopback and routing of the receive and transmit
// streams with the priorities of the diagnostic facilities.
// Assumes all stream bits and code levels are synchronous to ref_clk,
// one bit per clock at line rate, and APB runs on the same clock.
// Operation
// [R01] Remote loop when manual or automatic set
// [R02] Manual remote enable is loop bit 1
// [R03] Auto remote needs receive side and auto
// [R04] Remote enters/leaves after code over 5.1s
// [R05] Clearing auto ends automatic loop at once
// [R06] Status bit 7 shows automatic loop active
// [R07] Software keeps detector side fixed meanwhile
// [R08] Remote: receive data to shaper and system
// [R09] Transmit monitors keep watching system input
// [R10] Remote priorities; transmit alarm disabled
// [R11] Manual digital enable is loop bit 2
// [R12] Auto digital on transmit side, code 5.1s
// [R13] Digital: transmit data to decoder, line watched
// [R14] Digital priorities; receive alarm disabled
// [R15] Dual only with manual remote; no auto remote
// [R16] Dual: both streams looped, receive monitors looped
// [R17] Dual manual priorities; alarms disabled
// [R18] Manual remote plus auto digital priorities
// [R19] Analog loop forces remote and digital off
// [R20] Code levels qualified by clock timer
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "llc_map.vh"

module llc_top
#(
	parameter [31:0] PERSIST_CYCLES = `LLC_PERSIST_MS * `LLC_CLK_KHZ
)
(
	input  wire        ref_clk,
	input  wire        nrst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Inband code detector levels, per path
	input  wire        rx_act_code,
	input  wire        rx_deact_code,
	input  wire        tx_act_code,
	input  wire        tx_deact_code,
	// Data streams in
	input  wire        rx_line_data,
	input  wire        rx_ja_data,
	input  wire        tx_ja_data,
	input  wire        sys_tx_data,
	input  wire        system_transmit_clock_fault,
	// Pattern and alarm generators
	input  wire        rx_pattern_en,
	input  wire        rx_pattern_data,
	input  wire        tx_pattern_en,
	input  wire        tx_pattern_data,
	input  wire        rx_alarm_en,
	input  wire        tx_alarm_en,
	// Data streams out
	output reg         shaper_data,
	output reg         decoder_data,
	output reg         sys_rx_data,
	output reg         rx_monitor_data,
	output reg         tx_monitor_data,
	output reg         line_monitor_data,
	output reg         tx_clock_fault_report,
	// Loop state
	output reg         remote_active,
	output reg         digital_active,
	output reg         analog_active,
	output reg         auto_wrap_active_flag
);

	// Alarm indication is an all ones stream
	localparam ALARM_BIT = 1'b1;

	// Automatic loop states
	localparam [1:0] AUTO_IDLE    = 2'b00;
	localparam [1:0] AUTO_REMOTE  = 2'b01;
	localparam [1:0] AUTO_DIGITAL = 2'b10;

	reg  [3:0]  loop_ctrl;            // Loop control register
	reg         pattern_detector_side_sel; // 0 receive, 1 transmit
	reg  [1:0]  auto_state;           // Automatic loop state
	reg  [1:0]  next_auto_state;      // Next automatic loop state
	reg  [31:0] next_prdata;          // Read data for the setup cycle
	reg         next_slverr;          // Unmapped address flag
	reg         next_shaper;          // Next transmit line bit
	reg         next_sys_rx;          // Next system receive bit
	reg         next_decoder;         // Next decoder input bit
	wire        analog_wrap_en;       // Manual analog loop
	wire        remote_wrap_manual_en; // Manual remote loop
	wire        digital_wrap_manual_en; // Manual digital loop
	wire        auto_wrap_en;         // Automatic loop enable
	wire        wr_en;                // Write completes this edge
	wire        arm_remote;           // Automatic remote may run
	wire        arm_digital;          // Automatic digital may run
	wire [1:0]  code_level;           // Selected code levels
	wire [1:0]  code_held;            // Codes persisted long enough
	wire        remote_now;           // Remote loop in effect
	wire        digital_now;          // Digital loop in effect
	wire        auto_dig_now;         // Digital loop from automatic side
	wire        line_in;              // Line data after analog loop

	assign analog_wrap_en         = loop_ctrl[`LLC_ANALOG_BIT];
	// [R02] Manual remote bit
	assign remote_wrap_manual_en  = loop_ctrl[`LLC_REMOTE_BIT];
	// [R11] Manual digital bit
	assign digital_wrap_manual_en = loop_ctrl[`LLC_DIGITAL_BIT];
	assign auto_wrap_en           = loop_ctrl[`LLC_AUTO_BIT];
	assign wr_en = psel & penable & pready & pwrite;

	// Setup-cycle read mux and address decode
	always @*
	begin
		next_prdata = 32'h0000_0000;
		next_slverr = 1'b0;
		case (paddr)
			`LLC_LOOP_CTRL_ADDR:
				next_prdata[3:0] = loop_ctrl;
			`LLC_DETECT_CFG_ADDR:
				next_prdata[`LLC_SIDE_SEL_BIT] = pattern_detector_side_sel;
			`LLC_STATUS_ADDR:
			begin
				next_prdata[`LLC_ST_REMOTE_BIT]  = remote_active;
				next_prdata[`LLC_ST_DIGITAL_BIT] = digital_active;
				next_prdata[`LLC_ST_ANALOG_BIT]  = analog_active;
				// [R06] Automatic loop status
				next_prdata[`LLC_ST_AUTO_BIT]    = auto_wrap_active_flag;
			end
			default:
				next_slverr = 1'b1;
		endcase
	end

	// APB answer: ready in the access cycle, one wait-free transfer
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel & ~penable;
			if (psel && !penable)
			begin
				prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
				pslverr <= next_slverr;
			end
			else
			begin
				pslverr <= 1'b0;
			end
		end
	end

	// Register writes; status is read only
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			loop_ctrl                 <= `LLC_LOOP_CTRL_RST;
			pattern_detector_side_sel <= `LLC_DETECT_CFG_RST;
		end
		else if (wr_en && paddr == `LLC_LOOP_CTRL_ADDR)
		begin
			loop_ctrl <= pwdata[3:0];
		end
		else if (wr_en && paddr == `LLC_DETECT_CFG_ADDR)
		begin
			// Software leaves this alone during an automatic loop
			pattern_detector_side_sel <= pwdata[`LLC_SIDE_SEL_BIT];
		end
	end

	// [R03] Arming: receive side selected and auto set
	// [R15] Automatic remote unavailable while digital loop runs
	assign arm_remote  = auto_wrap_en & ~pattern_detector_side_sel &
		~digital_wrap_manual_en & ~analog_wrap_en;
	// [R12] Arming on the transmit side
	assign arm_digital = auto_wrap_en & pattern_detector_side_sel &
		~analog_wrap_en;

	// Detector codes come from the path the detector sits on
	assign code_level = pattern_detector_side_sel ?
		{tx_deact_code, tx_act_code} : {rx_deact_code, rx_act_code};

	// [R20] Persistence timer on the clock
	llc_persist
	#(
		.PERSIST_CYCLES (PERSIST_CYCLES)
	)
	u_persist
	(
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.code_level (code_level),
		.code_held  (code_held)
	);

	// Automatic loop state transitions
	always @*
	begin
		next_auto_state = auto_state;
		case (auto_state)
			AUTO_IDLE:
			begin
				// [R04] Activate code held over 5.1 s
				if (arm_remote && code_held[0])
					next_auto_state = AUTO_REMOTE;
				else if (arm_digital && code_held[0])
					next_auto_state = AUTO_DIGITAL;
			end
			AUTO_REMOTE:
			begin
				// [R05] Disarm ends the loop at once
				if (!arm_remote || code_held[1])
					next_auto_state = AUTO_IDLE;
			end
			AUTO_DIGITAL:
			begin
				// [R12] Deactivate code or disarm ends it
				if (!arm_digital || code_held[1])
					next_auto_state = AUTO_IDLE;
			end
			default:
				next_auto_state = AUTO_IDLE;
		endcase
	end

	// Automatic loop state register
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			auto_state <= AUTO_IDLE;
		else
			auto_state <= next_auto_state;
	end

	// [R19] Analog loop overrides remote and digital
	// [R01] Remote from manual or automatic
	assign remote_now   = ~analog_wrap_en &
		(remote_wrap_manual_en | (auto_state == AUTO_REMOTE));
	assign auto_dig_now = ~analog_wrap_en & (auto_state == AUTO_DIGITAL);
	assign digital_now  = ~analog_wrap_en &
		(digital_wrap_manual_en | auto_dig_now);

	// Analog loop replaces line data with the transmitted bit
	assign line_in = analog_wrap_en ? shaper_data : rx_line_data;

	// Stream routing with diagnostic priorities
	always @*
	begin
		// Decoder input
		// [R13] Digital loop feeds transmit data to the decoder
		next_decoder = digital_now ? tx_ja_data : line_in;
		// Receive toward the system
		if (rx_pattern_en)
			next_sys_rx = rx_pattern_data;
		else if (rx_alarm_en && !digital_now && !analog_wrap_en)
			// [R14] Receive alarm off in digital, dual, analog
			next_sys_rx = ALARM_BIT;
		else
			next_sys_rx = next_decoder;
		// Transmit toward the line
		if (remote_now && digital_now)
		begin
			// [R16] Dual: received line data loops to shaper
			// [R17] [R18] Looped data wins; alarm off
			next_shaper = rx_ja_data;
		end
		else if (remote_now)
		begin
			// [R08] Receive data to shaper, system input dropped
			// [R10] Pattern over looped data; alarm off
			next_shaper = tx_pattern_en ? tx_pattern_data : rx_ja_data;
		end
		else if (tx_pattern_en)
			next_shaper = tx_pattern_data;
		else if (digital_now || analog_wrap_en)
			// [R14] Transmit data ranks above alarm
			next_shaper = tx_ja_data;
		else if (tx_alarm_en)
			next_shaper = ALARM_BIT;
		else
			next_shaper = tx_ja_data;
	end

	// Registered stream outputs and monitor taps
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			shaper_data           <= 1'b0;
			decoder_data          <= 1'b0;
			sys_rx_data           <= 1'b0;
			rx_monitor_data       <= 1'b0;
			tx_monitor_data       <= 1'b0;
			line_monitor_data     <= 1'b0;
			tx_clock_fault_report <= 1'b0;
		end
		else
		begin
			shaper_data       <= next_shaper;
			decoder_data      <= next_decoder;
			sys_rx_data       <= next_sys_rx;
			// [R16] Receive detectors watch decoder input
			rx_monitor_data   <= next_decoder;
			// [R09] Transmit detectors watch system input
			tx_monitor_data   <= sys_tx_data;
			// [R13] Line loss and alarm watch line input
			line_monitor_data <= line_in;
			// [R08] Clock status ignored during remote loop
			tx_clock_fault_report <= system_transmit_clock_fault &
				~remote_now;
		end
	end

	// Registered loop state
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			remote_active         <= 1'b0;
			digital_active        <= 1'b0;
			analog_active         <= 1'b0;
			auto_wrap_active_flag <= 1'b0;
		end
		else
		begin
			remote_active         <= remote_now;
			digital_active        <= digital_now;
			analog_active         <= analog_wrap_en;
			// [R06] Flag follows the automatic state
			auto_wrap_active_flag <= (auto_state != AUTO_IDLE) &
				~analog_wrap_en;
		end
	end

endmodule

`default_nettype wire

// ### llc_top_sva.sv
// Checker for llc_top, bound to every instance at its ports.
// Assumes one clock domain and the active-low reset nrst.
`timescale 1ns/10ps
`default_nettype none
module llc_top_chk
#(
	parameter [31:0] PERSIST_CYCLES = 32'h0000_0014
)
(
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        rx_act_code,
	input wire logic        tx_act_code,
	input wire logic        rx_ja_data,
	input wire logic        rx_line_data,
	input wire logic        tx_ja_data,
	input wire logic        sys_tx_data,
	input wire logic        tx_pattern_en,
	input wire logic        tx_pattern_data,
	input wire logic        shaper_data,
	input wire logic        decoder_data,
	input wire logic        tx_monitor_data,
	input wire logic        rx_monitor_data,
	input wire logic        line_monitor_data,
	input wire logic        tx_clock_fault_report,
	input wire logic        remote_active,
	input wire logic        digital_active,
	input wire logic        analog_active,
	input wire logic        auto_wrap_active_flag
);
	// Edges in a row with an activate level present
	logic [31:0] act_run;
	// Loop control written at this edge
	wire         wr_loop;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	assign wr_loop = psel && penable && pready && pwrite && paddr == 12'h000;
	// Run counter, cleared when both levels drop
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			act_run <= 32'h0000_0000;
		else if (rx_act_code || tx_act_code)
			act_run <= act_run + 32'h0000_0001;
		else
			act_run <= 32'h0000_0000;
	end
	manual_remote_a: assert property (
		wr_loop && pwdata[1] && !pwdata[0] |-> ##2 remote_active)
		else $error("remote loop not entered");
	manual_digital_a: assert property (
		wr_loop && pwdata[2] && !pwdata[0] |-> ##2 digital_active)
		else $error("digital loop not entered");
	analog_force_a: assert property (
		wr_loop && pwdata[0]
		|-> ##2 analog_active && !remote_active && !digital_active)
		else $error("analog loop did not override");
	auto_clear_a: assert property (
		wr_loop && !pwdata[3] && auto_wrap_active_flag
		|-> ##[1:3] !auto_wrap_active_flag)
		else $error("automatic loop not stopped");
	persist_time_a: assert property (
		$rose(auto_wrap_active_flag) |-> act_run >= PERSIST_CYCLES)
		else $error("automatic loop entered too early");
	remote_route_a: assert property (
		(remote_active && !digital_active && !analog_active)[*4]
		|-> $past(shaper_data) == ($past(tx_pattern_en, 2) ?
		$past(tx_pattern_data, 2) : $past(rx_ja_data, 2)))
		else $error("remote shaper data wrong");
	digital_route_a: assert property (
		(digital_active && !remote_active && !analog_active)[*4]
		|-> $past(decoder_data) == $past(tx_ja_data, 2))
		else $error("digital decoder data wrong");
	dual_route_a: assert property (
		(remote_active && digital_active)[*4]
		|-> $past(shaper_data) == $past(rx_ja_data, 2))
		else $error("dual shaper data wrong");
	tx_watch_a: assert property (
		$past(nrst, 2) |-> tx_monitor_data == $past(sys_tx_data))
		else $error("transmit monitor data wrong");
	fault_hidden_a: assert property (
		remote_active[*3] |-> !$past(tx_clock_fault_report))
		else $error("clock fault shown in remote loop");
	rx_watch_a: assert property (
		(remote_active && digital_active)[*2]
		|-> $past(rx_monitor_data) == $past(tx_ja_data, 2))
		else $error("receive monitor data wrong");
	line_watch_a: assert property (
		(digital_active && !analog_active)[*2]
		|-> $past(line_monitor_data) == $past(rx_line_data, 2))
		else $error("line monitor data wrong");
endmodule
bind llc_top llc_top_chk #(.PERSIST_CYCLES(PERSIST_CYCLES)) chk (.*);
`default_nettype wire

// ### llc_framer.sv
// System side framer model: sends a fixed shift-register sequence
// and counts received ones. Assumes the reset nrst.
`timescale 1ns/10ps
`default_nettype none
module llc_framer
(
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       sys_rx_data,
	output var  logic       sys_tx_data,
	output var  logic [7:0] rx_ones
);
	// Sequence state, never all zero
	logic [4:0] seq;
	// One bit out and one bit in per clock
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			seq <= 5'h01;
			rx_ones <= 8'h00;
		end
		else
		begin
			seq <= {seq[3:0], seq[4] ^ seq[2]};
			rx_ones <= rx_ones + {7'h00, sys_rx_data};
		end
	end
	assign sys_tx_data = seq[4];
endmodule
`default_nettype wire

// ### llc_top_tb.sv
// Testbench for llc_top: APB tasks, counter driven streams and the
// framer model. Assumes 100 MHz and a persistence count of 20.
`timescale 1ns/10ps
`default_nettype none
`include "llc_map.vh"
module llc_top_tb;
	localparam logic [31:0] P = 32'h0000_0014;
	logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        rx_act_code, rx_deact_code, tx_act_code, sys_tx_data;
	logic        tx_deact_code;
	logic        shaper_data, decoder_data, sys_rx_data, exp_rx;
	logic        remote_active, digital_active, analog_active, auto_flag;
	logic [3:0]  cnt;
	int          fail_count, checked, n;
	llc_top #(.PERSIST_CYCLES(P)) dut (.ref_clk, .nrst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_act_code, .rx_deact_code, .tx_act_code, .tx_deact_code,
		.rx_line_data(cnt[0]), .rx_ja_data(cnt[1]),
		.tx_ja_data(cnt[0] ^ cnt[2]), .sys_tx_data,
		.system_transmit_clock_fault(cnt[2]),
		.rx_pattern_en(cnt[3] & cnt[0]), .rx_pattern_data(cnt[1] ^ cnt[3]),
		.tx_pattern_en(cnt[2] & cnt[3]), .tx_pattern_data(~cnt[1]),
		.rx_alarm_en(1'h1), .tx_alarm_en(1'h1), .shaper_data,
		.decoder_data, .sys_rx_data, .rx_monitor_data(), .tx_monitor_data(),
		.line_monitor_data(), .tx_clock_fault_report(), .remote_active,
		.digital_active, .analog_active, .auto_wrap_active_flag(auto_flag));
	llc_framer frm (.ref_clk, .nrst, .sys_rx_data, .sys_tx_data,
		.rx_ones());
	// Clock, 10 ns period
	initial
	begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Stream stimulus and the expected system receive bit
	always @(posedge ref_clk)
	begin
		cnt <= cnt + 4'h1;
		exp_rx <= (cnt[3] & cnt[0]) ? cnt[1] ^ cnt[3] : cnt[0] ^ cnt[2];
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		k = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (pready !== 1'h1 && k < 16);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1)
		begin
			fail_count++;
			end_sim();
		end
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask
	task automatic rd(input string nm, input logic [11:0] a,
		input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0000_0000, r, e);
		chk(nm, x, r);
		chk("slave error", {31'h0, xe}, {31'h0, e});
	endtask
	// Edges until remote (s 0) or digital (s 1) reaches level v
	task automatic wait_lvl(input int s, input logic v);
		n = 0;
		while (((s == 0) ? remote_active : digital_active) !== v)
		begin
			@(posedge ref_clk);
			n++;
			if (n > 200)
			begin
				fail_count++;
				end_sim();
			end
		end
	endtask
	// System receive follows looped data or receive pattern
	task automatic dual_rx();
		repeat (8)
		begin
			@(negedge ref_clk);
			chk("system receive", {31'h0, exp_rx}, {31'h0, sys_rx_data});
		end
		@(posedge ref_clk);
	endtask
	initial
	begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{rx_act_code, rx_deact_code, tx_act_code, cnt, exp_rx} = '0;
		tx_deact_code = 1'h0;
		fail_count = 0;
		checked = 0;
		repeat (16) @(posedge ref_clk);
		nrst <= 1'h1;
		@(posedge ref_clk);
		rd("loop reset", `LLC_LOOP_CTRL_ADDR, 32'h0000_0000, 1'h0);
		rd("detect reset", `LLC_DETECT_CFG_ADDR, 32'h0000_0000, 1'h0);
		wr(`LLC_STATUS_ADDR, 32'hFFFF_FFFF);
		rd("status", `LLC_STATUS_ADDR, 32'h0000_0000, 1'h0);
		rd("unmapped", 12'h00C, 32'h0000_0000, 1'h1);
		wr(`LLC_DETECT_CFG_ADDR, 32'hFFFF_FFFF);
		rd("detect side", `LLC_DETECT_CFG_ADDR, 32'h0000_0008, 1'h0);
		$display("test registers done");
		wr(`LLC_DETECT_CFG_ADDR, 32'h0000_0000);
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_0002);
		repeat (40) @(posedge ref_clk);
		rd("remote status", `LLC_STATUS_ADDR, 32'h0000_0001, 1'h0);
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_0008);
		// Let the manual remote loop drain before timing the entry
		@(posedge ref_clk);
		rx_act_code <= 1'h1;
		wait_lvl(0, 1'h1);
		chk("remote entry", 1, n >= P + 2 && n <= P + 6);
		rx_act_code <= 1'h0;
		rd("auto status", `LLC_STATUS_ADDR, 32'h0000_0081, 1'h0);
		rx_deact_code <= 1'h1;
		wait_lvl(0, 1'h0);
		chk("remote exit", 1, n >= P + 2 && n <= P + 6);
		rx_deact_code <= 1'h0;
		rx_act_code <= 1'h1;
		wait_lvl(0, 1'h1);
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_0000);
		wait_lvl(0, 1'h0);
		chk("auto stop", 1, n <= 3);
		rx_act_code <= 1'h0;
		$display("test remote done");
		wr(`LLC_DETECT_CFG_ADDR, 32'h0000_0008);
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_0008);
		tx_act_code <= 1'h1;
		wait_lvl(1, 1'h1);
		chk("digital entry", 1, n >= P + 2 && n <= P + 6);
		tx_act_code <= 1'h0;
		repeat (30) @(posedge ref_clk);
		rd("digital status", `LLC_STATUS_ADDR, 32'h0000_0082, 1'h0);
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_000A);
		repeat (6) @(posedge ref_clk);
		dual_rx();
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_0000);
		wait_lvl(1, 1'h0);
		chk("digital stop", 1, n <= 3);
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_0008);
		tx_act_code <= 1'h1;
		wait_lvl(1, 1'h1);
		tx_act_code <= 1'h0;
		tx_deact_code <= 1'h1;
		wait_lvl(1, 1'h0);
		chk("digital exit", 1, n >= P + 2 && n <= P + 6);
		tx_deact_code <= 1'h0;
		$display("test digital done");
		wr(`LLC_DETECT_CFG_ADDR, 32'h0000_0000);
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_000C);
		rx_act_code <= 1'h1;
		repeat (P + 20) @(posedge ref_clk);
		chk("no auto remote", 0, remote_active);
		rx_act_code <= 1'h0;
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_0007);
		rd("analog status", `LLC_STATUS_ADDR, 32'h0000_0004, 1'h0);
		wr(`LLC_LOOP_CTRL_ADDR, 32'h0000_0006);
		repeat (6) @(posedge ref_clk);
		dual_rx();
		$display("test dual done");
		end_sim();
	end
endmodule
`default_nettype wire
